// [ftbs_pkg.sv]
package ftbs_pkg;
  // =====================================================================
  // Array geometry.
  localparam int ADDR_W     = 18;
  localparam int BURST_W    = 2;
  localparam int LANES      = 2;
  localparam int BYTE_W     = 8;
  localparam int DATA_W     = LANES * BYTE_W;
  localparam int DEPTH      = 1 << ADDR_W;
  // =====================================================================
  // Sleep entry and exit latency, in clock cycles.
  localparam int SLEEP_CYCLES = 2;
  localparam logic [1:0] SLEEP_CNT_ONE  = 2'h1;
  localparam logic [1:0] SLEEP_CNT_LAST = 2'(SLEEP_CYCLES - 1);
  localparam logic [1:0] SLEEP_CNT_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
  // =====================================================================
  // Sleep state machine.
  typedef enum logic [1:0] {
    FTBS_AWAKE,
    FTBS_ENTERING,
    FTBS_ASLEEP,
    FTBS_WAKING
  } ftbs_sleep_t;
endpackage

// [ftbs_sleep_ctrl.sv]
module ftbs_sleep_ctrl (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Sleep request pin and state.
  input  wire logic sleepRequest,
  output logic      asleep,
  output logic      entering
);
  // =====================================================================
  // Synchroniser.
  logic sync1;
  logic sync2;
  logic [1:0] count;
  ftbs_pkg::ftbs_sleep_t state;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= sleepRequest;
      sync2 <= sync1;
    end
  end

  // =====================================================================
  // Entry and exit each take two cycles.
  // sleep entry exit
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ftbs_pkg::FTBS_AWAKE;
      count <= ftbs_pkg::SLEEP_CNT_ZERO;
    end else begin
      case (state)
        ftbs_pkg::FTBS_AWAKE: begin
          if (sync2) begin
            state <= ftbs_pkg::FTBS_ENTERING;
            count <= ftbs_pkg::SLEEP_CNT_ONE;
          end
        end
        ftbs_pkg::FTBS_ENTERING: begin
          if (count == ftbs_pkg::SLEEP_CNT_LAST) begin
            state <= ftbs_pkg::FTBS_ASLEEP;
          end else begin
            count <= count + ftbs_pkg::SLEEP_CNT_ONE;
          end
        end
        ftbs_pkg::FTBS_ASLEEP: begin
          if (!sync2) begin
            state <= ftbs_pkg::FTBS_WAKING;
            count <= ftbs_pkg::SLEEP_CNT_ONE;
          end
        end
        ftbs_pkg::FTBS_WAKING: begin
          if (count == ftbs_pkg::SLEEP_CNT_LAST) begin
            state <= ftbs_pkg::FTBS_AWAKE;
          end else begin
            count <= count + ftbs_pkg::SLEEP_CNT_ONE;
          end
        end
        default: begin
          state <= ftbs_pkg::FTBS_AWAKE;
        end
      endcase
    end
  end

  assign asleep   = (state != ftbs_pkg::FTBS_AWAKE);
  assign entering = (state == ftbs_pkg::FTBS_ENTERING);

  a_sleep_entry_time: assert property (@(posedge clk) disable iff (rst)
    $rose(sync2) && state == ftbs_pkg::FTBS_AWAKE |=> entering ##1 state == ftbs_pkg::FTBS_ASLEEP)
    else $error("sleep entry did not take two cycles");

  a_sleep_exit_time: assert property (@(posedge clk) disable iff (rst)
    $fell(sync2) && state == ftbs_pkg::FTBS_ASLEEP |=> state == ftbs_pkg::FTBS_WAKING ##1 !asleep)
    else $error("sleep exit did not take two cycles");
endmodule

// [ftbs_sram_core.sv]
// Operation
// - Clock qualifier high freezes address, burst count and pending operation.
// - Read starts on qualified edge, chips selected, write request high, load.
// - Read data flows out same cycle, driven only while output enable low.
// - New operation accepted every qualified edge, no wait states.
// - Inactive chip select on load deselects and tri-states immediately.
// - Burst counter allows four accesses from one loaded address.
// - Strap low gives linear order, high gives interleaved XOR order.
// - Counter touches only two low address bits, wrapping within group.
// - Advance ignores chip selects and write request, advances counter.
// - Access type captured at load and kept for the burst.
// - Write starts when selected, write request low, load; lanes sampled with data.
// - Write data captured at next qualified edge, completing write.
// - Only byte lanes with active-low select are updated.
// - Data and parity outputs tri-stated during write data phase.
// - Parity lanes follow their data byte lanes.
// - Sleep entry and exit each take two clock cycles.
// - Access pending at sleep entry is invalid.
// - Outputs tri-stated first clock after leaving deselect.
// - Write with no lanes selected modifies nothing, lines tri-stated.
// - Device starts deselected with data lines tri-stated.
module ftbs_sram_core (
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Control inputs.
  input  wire logic                          clock_qualifier_n,
  input  wire logic                          advance_or_load,
  input  wire logic                          write_request_n,
  input  wire logic                          chip_select_first_n,
  input  wire logic                          chip_select_second,
  input  wire logic                          chip_select_third_n,
  input  wire logic                          output_drive_n,
  input  wire logic                          burst_order,
  input  wire logic                          sleep_request,
  // Address and lane selects.
  input  wire logic [ftbs_pkg::ADDR_W-1:0]   address,
  input  wire logic [ftbs_pkg::LANES-1:0]    byte_lane_select_n,
  // Data lines.
  input  wire logic [ftbs_pkg::DATA_W-1:0]   dataIn,
  output logic      [ftbs_pkg::DATA_W-1:0]   dataOut,
  output logic      [ftbs_pkg::DATA_W-1:0]   dataOe_n,
  // Parity lines.
  input  wire logic [ftbs_pkg::LANES-1:0]    parityIn,
  output logic      [ftbs_pkg::LANES-1:0]    parityOut,
  output logic      [ftbs_pkg::LANES-1:0]    parity_lines_oe_n,
  // Status.
  output logic                               sleeping
);
  // =====================================================================
  // Storage. Parity is a ninth bit of each byte lane.
  localparam int LANE_W = ftbs_pkg::BYTE_W + 1;
  logic [LANE_W-1:0] mem [ftbs_pkg::LANES][ftbs_pkg::DEPTH];

  logic                                 active;
  logic                                 isWrite;
  logic                                 wasDeselected;
  logic                                 firstAfter;
  logic [ftbs_pkg::ADDR_W-1:0]          baseAddr;
  logic [ftbs_pkg::BURST_W-1:0]         beat;
  logic [ftbs_pkg::ADDR_W-1:0]          curAddr;
  logic [ftbs_pkg::BURST_W-1:0]         lowBits;
  logic [ftbs_pkg::DATA_W-1:0]          readData;
  logic [ftbs_pkg::LANES-1:0]           readPar;
  logic                                 qualified;
  logic                                 selected;
  logic                                 load;
  logic                                 writePhase;
  logic                                 drive;
  logic                                 asleep;
  logic                                 entering;

  ftbs_sleep_ctrl u_sleep (
    .clk          (clk),
    .rst          (rst),
    .sleepRequest (sleep_request),
    .asleep       (asleep),
    .entering     (entering)
  );

  assign sleeping  = asleep;
  assign qualified = !clock_qualifier_n && !asleep;
  assign selected  = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  assign load      = qualified && !advance_or_load;

  // =====================================================================
  // Control registers.
  // stall holds state
  always_ff @(posedge clk) begin
    if (rst || entering) begin
      active        <= 1'b0;
      isWrite       <= 1'b0;
      wasDeselected <= 1'b1;
      firstAfter    <= 1'b0;
    end else if (load) begin
      active        <= selected;
      isWrite       <= selected && !write_request_n;
      wasDeselected <= !selected;
      firstAfter    <= selected && wasDeselected;
    end else if (qualified) begin
      firstAfter    <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      baseAddr <= '0;
      beat     <= ftbs_pkg::BURST_ZERO;
    end else if (load) begin
      baseAddr <= address;
      beat     <= ftbs_pkg::BURST_ZERO;
    end else if (qualified) begin
      beat     <= beat + ftbs_pkg::BURST_ONE;
    end
  end

  // =====================================================================
  // Burst address.
  // linear or interleaved
  always_comb begin
    if (burst_order) begin
      lowBits = baseAddr[ftbs_pkg::BURST_W-1:0] ^ beat;
    end else begin
      lowBits = baseAddr[ftbs_pkg::BURST_W-1:0] + beat;
    end
    curAddr = {baseAddr[ftbs_pkg::ADDR_W-1:ftbs_pkg::BURST_W], lowBits};
  end

  assign writePhase = active && isWrite;

  // =====================================================================
  // Write path: data captured at the edge after the command or beat.
  // write data capture
  for (genvar g = 0; g < ftbs_pkg::LANES; g++) begin : g_lane
    always_ff @(posedge clk) begin
      if (!rst && qualified && writePhase && !byte_lane_select_n[g]) begin
        mem[g][curAddr] <= {parityIn[g], dataIn[g*ftbs_pkg::BYTE_W +: ftbs_pkg::BYTE_W]};
      end
    end
    assign readData[g*ftbs_pkg::BYTE_W +: ftbs_pkg::BYTE_W] = mem[g][curAddr][ftbs_pkg::BYTE_W-1:0];
    assign readPar[g] = mem[g][curAddr][ftbs_pkg::BYTE_W];
  end

  // =====================================================================
  // Output drive. Flow-through read data comes straight from the array,
  // which trades a register stage for zero read latency.
  // flow-through read
  assign drive = active && !isWrite && !firstAfter && !output_drive_n && !asleep;
  assign dataOut   = readData;
  assign parityOut = readPar;
  assign dataOe_n  = {ftbs_pkg::DATA_W{!drive}};
  assign parity_lines_oe_n = {ftbs_pkg::LANES{!drive}};

  // =====================================================================
  // Checks.
  a_stall_holds_addr: assert property (@(posedge clk) disable iff (rst)
    clock_qualifier_n && !entering |=> $stable(curAddr) && $stable(active))
    else $error("stalled edge changed state");

  a_read_loads_addr: assert property (@(posedge clk) disable iff (rst)
    load && selected && write_request_n && !entering |=> active && !isWrite && baseAddr == $past(address))
    else $error("read did not load");

  a_write_never_drives: assert property (@(posedge clk) disable iff (rst)
    writePhase |-> dataOe_n == {ftbs_pkg::DATA_W{1'b1}} && parity_lines_oe_n == {ftbs_pkg::LANES{1'b1}})
    else $error("bus driven in write phase");

  a_deselect_tristates: assert property (@(posedge clk) disable iff (rst)
    load && !selected |=> !active && dataOe_n == {ftbs_pkg::DATA_W{1'b1}})
    else $error("deselect did not tri-state");

  a_burst_wraps_four: assert property (@(posedge clk) disable iff (rst)
    load && !entering ##1 (qualified && advance_or_load)[*4] |=> curAddr == $past(baseAddr, 1) && beat == ftbs_pkg::BURST_ZERO)
    else $error("burst did not wrap in four");

  a_advance_keeps_type: assert property (@(posedge clk) disable iff (rst)
    qualified && advance_or_load && !entering |=> $stable(isWrite) && $stable(active))
    else $error("advance changed access type");

  a_first_clock_masked: assert property (@(posedge clk) disable iff (rst)
    load && selected && wasDeselected && !entering |=> dataOe_n == {ftbs_pkg::DATA_W{1'b1}})
    else $error("drove first clock after deselect");

  a_read_drive_follows: assert property (@(posedge clk) disable iff (rst)
    active && !isWrite && !firstAfter && !asleep && !output_drive_n |-> dataOe_n == '0 && dataOut == readData)
    else $error("read data not driven");

  a_linear_order: assert property (@(posedge clk) disable iff (rst)
    !burst_order && beat == ftbs_pkg::BURST_ONE |-> lowBits == baseAddr[1:0] + ftbs_pkg::BURST_ONE)
    else $error("linear order wrong");
endmodule

// [ftbs_host_model.sv]
module ftbs_host_model (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Host drive side.
  input  wire logic                        hostDrive,
  input  wire logic [ftbs_pkg::DATA_W-1:0] hostData,
  input  wire logic [ftbs_pkg::LANES-1:0]  hostParity,
  // Device drive side.
  input  wire logic [ftbs_pkg::DATA_W-1:0] dataOut,
  input  wire logic [ftbs_pkg::DATA_W-1:0] dataOe_n,
  input  wire logic [ftbs_pkg::LANES-1:0]  parityOut,
  input  wire logic [ftbs_pkg::LANES-1:0]  parityOe_n,
  // Resolved lines.
  output logic      [ftbs_pkg::DATA_W-1:0] dataIn,
  output logic      [ftbs_pkg::LANES-1:0]  parityIn,
  output logic                             contentionSeen
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int W = ftbs_pkg::DATA_W + ftbs_pkg::LANES;
  logic [W-1:0] busNow;
  logic [W-1:0] lastBus;
  logic [W-1:0] oeN;
  logic [W-1:0] devBus;
  logic [W-1:0] hostBus;
  // =====================================================================
  // Line resolution.
  // A floating line shows the inverse of its last level, so stale data does not read back as good on the first clock it floats.
  assign oeN     = {dataOe_n, parityOe_n};
  assign devBus  = {dataOut, parityOut};
  assign hostBus = {hostData, hostParity};
  always_comb begin
    for (int i = 0; i < W; i++) begin
      busNow[i] = !oeN[i] ? devBus[i] : (hostDrive ? hostBus[i] : ~lastBus[i]);
    end
  end
  assign {dataIn, parityIn} = busNow;
  always_ff @(posedge clk) begin
    if (rst) begin
      lastBus <= '0;
    end else begin
      lastBus <= busNow;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      contentionSeen <= 1'b0;
    end else if (hostDrive && !(&{dataOe_n, parityOe_n})) begin
      contentionSeen <= 1'b1;
    end
  end
endmodule

// [flow_through_burst_sram_control_tb_top.sv]
module flow_through_burst_sram_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [17:0] BASE = 18'h0_0a48;
  logic        clk, rst, clkQualN, advLoad, writeReqN, csFirstN, csSecond, csThirdN;
  logic        outDriveN, burstOrder, sleepReq, hostDrive, sleeping, contention;
  logic [17:0] addr;
  logic [15:0] dataIn, dataOut, dataOeN, hostData;
  logic [1:0]  laneSelN, parityIn, parityOut, parityOeN, hostParity;
  logic [15:0] emData [4];
  logic [1:0]  emPar [4];
  int          numErrors, checkCount;
  ftbs_sram_core DUT (.clk(clk), .rst(rst), .clock_qualifier_n(clkQualN), .advance_or_load(advLoad),
    .write_request_n(writeReqN), .chip_select_first_n(csFirstN), .chip_select_second(csSecond),
    .chip_select_third_n(csThirdN), .output_drive_n(outDriveN), .burst_order(burstOrder),
    .sleep_request(sleepReq), .address(addr), .byte_lane_select_n(laneSelN), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe_n(dataOeN), .parityIn(parityIn), .parityOut(parityOut),
    .parity_lines_oe_n(parityOeN), .sleeping(sleeping));
  ftbs_host_model host (.clk(clk), .rst(rst), .hostDrive(hostDrive), .hostData(hostData),
    .hostParity(hostParity), .dataOut(dataOut), .dataOe_n(dataOeN), .parityOut(parityOut),
    .parityOe_n(parityOeN), .dataIn(dataIn), .parityIn(parityIn), .contentionSeen(contention));
  // =====================================================================
  // Shared tasks.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Chip select code 0 selects; codes 1 to 3 each drop one select.
  task automatic step(input logic q, a, input logic [1:0] c, input logic w, input logic [1:0] s,
                      input logic [1:0] bl, input logic h, input logic [15:0] d, input logic [1:0] p);
    @(posedge clk);
    clkQualN <= q; outDriveN <= q; advLoad <= a; writeReqN <= w;
    csFirstN <= (c == 2'h1); csSecond <= (c != 2'h2); csThirdN <= (c == 2'h3);
    addr <= BASE | 18'(s); laneSelN <= bl; hostDrive <= h; hostData <= d; hostParity <= p;
  endtask
  // =====================================================================
  // Scenarios.
  // Advance beats drive junk selects and access type, which the burst must ignore.
  // The last beat loads a deselect, so every read burst starts from one.
  task automatic wr(input logic [1:0] s, input logic [1:0] bl, input logic [15:0] d);
    logic [1:0]  ix;
    logic [15:0] v;
    step(0, 0, 2'h0, 0, s, bl, 0, d, 2'h0);
    for (int k = 0; k < 4; k++) begin
      ix = burstOrder ? s ^ 2'(k) : s + 2'(k);
      v = d + 16'(k);
      step(0, k < 3, k < 3 ? 2'(k + 1) : 2'h1, 1, 2'(k + 2), bl, 1, v, 2'(k));
      #1;
      check("write oe", {dataOeN, parityOeN}, 18'h3_ffff);
      if (!bl[0]) begin
        emData[ix][7:0] = v[7:0];
        emPar[ix][0] = k[0];
      end
      if (!bl[1]) begin
        emData[ix][15:8] = v[15:8];
        emPar[ix][1] = k[1];
      end
    end
    $display("write burst done start %0d lanes %b", s, bl);
  endtask
  task automatic rd(input logic [1:0] s, input logic o, input logic st, input logic [1:0] dc);
    logic [1:0] ix;
    @(posedge clk) burstOrder <= o;
    step(0, 0, 2'h0, 1, s, 2'h3, 0, 16'h0000, 2'h0);
    // The fifth beat wraps back to the start word.
    for (int k = 0; k < 5; k++) begin
      ix = o ? s ^ 2'(k) : s + 2'(k);
      if (st && k == 2) begin
        step(1, 1, 2'h1, 0, 2'h0, 2'h3, 0, 16'h0000, 2'h0);
        #1;
        check("stall oe", {dataOeN, parityOeN}, 18'h3_ffff);
        check("stall data", dataOut, emData[ix]);
      end
      step(0, k < 4, k < 4 ? 2'(k) : dc, 0, 2'(k + 1), 2'h3, 0, 16'h0000, 2'h0);
      #1;
      check("read data", {parityOut, dataOut}, {emPar[ix], emData[ix]});
      check("read oe", {dataOeN, parityOeN}, k == 0 ? 18'h3_ffff : 18'h0_0000);
    end
    step(0, 1, 2'h0, 1, 2'h0, 2'h3, 0, 16'h0000, 2'h0);
    #1;
    check("deselect oe", {dataOeN, parityOeN}, 18'h3_ffff);
    $display("read burst done start %0d order %0d", s, o);
  endtask
  task automatic sleep_test();
    int n;
    step(0, 0, 2'h1, 1, 2'h0, 2'h3, 0, 16'h0000, 2'h0);
    @(posedge clk) sleepReq <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (sleeping !== 1'b1 && n < 10);
    check("sleep entry", 32'(n), 32'h0000_0003);
    repeat (4) @(posedge clk);
    sleepReq <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (sleeping !== 1'b0 && n < 10);
    check("sleep exit", sleeping, 32'h0000_0000);
    check("sleep exit time", 32'(n), 32'h0000_0004);
    repeat (2) step(0, 0, 2'h1, 1, 2'h0, 2'h3, 0, 16'h0000, 2'h0);
    $display("sleep test done");
  endtask
  // =====================================================================
  // Main sequence and watchdog.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #4000;
    numErrors++;
    complete_run();
  end
  initial begin
    {clkQualN, advLoad, writeReqN, csFirstN, csSecond, csThirdN} = 6'h39;
    {outDriveN, burstOrder, sleepReq, hostDrive, addr, laneSelN} = '0;
    {hostData, hostParity} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("reset oe", {dataOeN, parityOeN}, 18'h3_ffff);
    check("reset sleep", sleeping, 32'h0000_0000);
    wr(2'h1, 2'h0, 16'h4560);
    for (int i = 0; i < 4; i++) begin
      rd(2'(i), 0, i == 1, 2'(i % 3 + 1));
      rd(2'(i), 1, 0, 2'h3);
    end
    wr(2'h2, 2'h2, 16'h7890);
    wr(2'h3, 2'h3, 16'hbcd0);
    rd(2'h0, 0, 0, 2'h2);
    sleep_test();
    rd(2'h3, 1, 0, 2'h1);
    check("contention", contention, 32'h0000_0000);
    complete_run();
  end
endmodule
